// ---- fl2c_top.sv ----
// Two-way write-through first-level cache between CPU and memory bus.
// Assumes the bus holds a request until i_bus_ack and inputs are
// synchronous to i_clk.
`default_nettype none

module fl2c_top (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_cpu_valid,
    input wire fl2c_pkg::fl2c_cpu_req_t i_cpu,
    output logic o_cpu_ready,
    output logic o_cpu_ack,
    output logic [31:0] o_cpu_rdata,
    output logic o_mcheck,
    output logic o_prefetch_halt,
    input wire logic i_rei,
    input wire logic i_dma_wr,
    input wire logic [29:0] i_dma_addr,
    input wire logic i_ipr_wr,
    input wire logic [5:0] i_ipr_addr,
    input wire logic [31:0] i_ipr_wdata,
    output logic [31:0] o_ipr_rdata,
    output logic o_bus_valid,
    output fl2c_pkg::fl2c_bus_req_t o_bus,
    input wire logic i_bus_ack,
    input wire logic [31:0] i_bus_rdata,
    input wire logic i_bus_perr
);
    typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_FILL} fl2c_state_t;

    // ************************************************************
    // Storage
    // ************************************************************
    // Tag store keeps {parity, tag}; valid bits live apart so a flush
    // can clear them all in one edge.
    logic [20:0] tag_mem [2][64];
    logic [71:0] dat_mem [2][64];
    logic [127:0] valid_reg;
    logic [7:0] cfg_reg;
    logic [7:0] log_reg;
    fl2c_state_t st_reg;
    fl2c_pkg::fl2c_cpu_req_t req_reg;
    fl2c_pkg::fl2c_bus_req_t bus_reg;
    logic cach_reg, kill_reg, victim_reg;
    logic [31:0] first_reg;

    // ************************************************************
    // Parity and lookup
    // ************************************************************
    function automatic logic [8:0] enc_byte(input logic [7:0] b,
                                            input logic odd,
                                            input logic bad);
        enc_byte = {(odd ? ~^b : ^b) ^ bad, b};
    endfunction

    function automatic logic [35:0] enc_lw(input logic [31:0] d,
                                           input logic bad);
        enc_lw = '0;
        for (int j = 0; j < 4; j++) begin
            enc_lw[9*j +: 9] = enc_byte(d[8*j +: 8], j[0], bad);
        end
    endfunction

    function automatic logic lw_bad(input logic [35:0] s);
        lw_bad = 1'b0;
        for (int j = 0; j < 4; j++) begin
            lw_bad = lw_bad |
                (s[9*j +: 9] != enc_byte(s[9*j +: 8], j[0], 1'b0));
        end
    endfunction

    function automatic logic [31:0] strip(input logic [35:0] s);
        strip = {s[34:27], s[25:18], s[16:9], s[7:0]};
    endfunction

    function automatic logic [20:0] enc_tag(input logic [19:0] t,
                                            input logic bad);
        enc_tag = {~^t ^ bad, t};
    endfunction

    function automatic logic [1:0] hits(input logic [29:0] a,
                                        input logic [1:0] en);
        logic [5:0] r;
        r = a[fl2c_pkg::IDX_LO +: fl2c_pkg::ROW_W];
        for (int s = 0; s < 2; s++) begin
            hits[s] = valid_reg[{s[0], r}] && en[s] &&
                tag_mem[s][r][19:0] ==
                a[fl2c_pkg::TAG_LO +: fl2c_pkg::TAG_W];
        end
    endfunction

    // ************************************************************
    // Decode
    // ************************************************************
    logic [1:0] en, chit, dhit;
    logic cache_on, is_only, test, badp, take, cach, lw, hset, dset;
    logic [5:0] row, drow;
    logic tag_err, dat_err, dtag_err, rd_hit, perr, wperr, dperr;
    logic dem_err, dma_inv, flush, busp, bus_mc, kill_now, fill_do;
    logic wr_do, ws, vs, chit_any, log_clr;
    logic [35:0] hd;
    logic [6:0] log_set;
    logic [71:0] wdat, qword;

    assign en = {cfg_reg[fl2c_pkg::CFG_EN1],
                 cfg_reg[fl2c_pkg::CFG_EN0]};
    assign cache_on = (|en) && (cfg_reg[fl2c_pkg::CFG_IS] |
                                cfg_reg[fl2c_pkg::CFG_DS]);
    assign is_only = cfg_reg[fl2c_pkg::CFG_IS] &
                     ~cfg_reg[fl2c_pkg::CFG_DS];
    assign test = cfg_reg[fl2c_pkg::CFG_TEST];
    assign badp = cfg_reg[fl2c_pkg::CFG_BADP];
    assign take = i_cpu_valid && st_reg == ST_IDLE;
    assign row = i_cpu.addr[fl2c_pkg::IDX_LO +: fl2c_pkg::ROW_W];
    assign lw = i_cpu.addr[fl2c_pkg::LW_BIT];
    // A process, not an assign, so fills and flushes re-run the lookup
    always_comb begin
        chit = hits(i_cpu.addr, en);
        dhit = hits(i_dma_addr, en);
    end
    assign chit_any = |chit;
    assign hset = ~chit[0];
    assign hd = lw ? dat_mem[hset][row][71:36] : dat_mem[hset][row][35:0];
    assign tag_err = enc_tag(tag_mem[hset][row][19:0], 1'b0) !=
                     tag_mem[hset][row];
    assign dat_err = lw_bad(hd);
    // Memory-space non-locked reads of an enabled stream only
    assign cach = !i_cpu.addr[fl2c_pkg::IO_BIT] && !i_cpu.write &&
        !i_cpu.lock && cache_on &&
        (i_cpu.istream ? cfg_reg[fl2c_pkg::CFG_IS]
                       : cfg_reg[fl2c_pkg::CFG_DS]);
    assign rd_hit = take && cach && chit_any;
    assign perr = rd_hit && !test && (tag_err || dat_err);
    assign wperr = take && i_cpu.write && chit_any && !test &&
                   tag_err;
    assign dem_err = perr && !i_cpu.istream && i_cpu.demand;

    assign drow = i_dma_addr[fl2c_pkg::IDX_LO +: fl2c_pkg::ROW_W];
    assign dset = ~dhit[0];
    assign dtag_err = enc_tag(tag_mem[dset][drow][19:0], 1'b0) !=
                      tag_mem[dset][drow];
    // In I-stream-only mode DMA writes are covered by the flush on return
    assign dma_inv = i_dma_wr && (|dhit) && !is_only;
    assign dperr = dma_inv && !test && dtag_err;

    assign flush = (i_ipr_wr && i_ipr_addr == fl2c_pkg::IPR_CFG &&
                    !i_ipr_wdata[fl2c_pkg::CFG_TEST]) ||
                   (i_rei && is_only) ||
                   perr || wperr || dperr;

    assign busp = i_bus_ack && i_bus_perr && st_reg != ST_IDLE &&
                  !req_reg.write;
    assign bus_mc = busp && st_reg == ST_FIRST && !req_reg.istream &&
                    req_reg.demand;
    assign kill_now = flush || (i_dma_wr && drow ==
        req_reg.addr[fl2c_pkg::IDX_LO +: fl2c_pkg::ROW_W]);
    assign fill_do = st_reg == ST_FILL && i_bus_ack && !i_bus_perr &&
                     !kill_reg && !kill_now;
    // Victim alternates when both sets are on, else the one that is on
    assign vs = (&en) ? victim_reg : en[1];
    assign ws = chit[0] ? 1'b0 : (chit[1] ? 1'b1 : (en[1] && !en[0]));
    assign wr_do = take && i_cpu.write &&
                   !i_cpu.addr[fl2c_pkg::IO_BIT] && !wperr &&
                   (chit_any || (test && (|en)));
    assign log_clr = i_ipr_wr && i_ipr_addr == fl2c_pkg::IPR_LOG;

    always_comb begin
        log_set = '0;
        if (perr || wperr) begin
            log_set[fl2c_pkg::LOG_W1] = hset;
            log_set[fl2c_pkg::LOG_W0] = ~hset;
            log_set[fl2c_pkg::LOG_TAG] = tag_err;
            log_set[fl2c_pkg::LOG_DAT] = perr && dat_err;
        end
        if (dperr) begin
            log_set[fl2c_pkg::LOG_W1] = log_set[fl2c_pkg::LOG_W1] | dset;
            log_set[fl2c_pkg::LOG_W0] = log_set[fl2c_pkg::LOG_W0] | ~dset;
            log_set[fl2c_pkg::LOG_TAG] = 1'b1;
        end
        log_set[fl2c_pkg::LOG_L1MC] = dem_err;
        log_set[fl2c_pkg::LOG_BUSMC] = dem_err || bus_mc;
        log_set[fl2c_pkg::LOG_BUS] = busp;
    end

    always_comb begin
        wdat = dat_mem[ws][row];
        for (int j = 0; j < 4; j++) begin
            if (i_cpu.be[j]) begin
                wdat[36*lw + 9*j +: 9] =
                    enc_byte(i_cpu.wdata[8*j +: 8], j[0], badp);
            end
        end
        if (req_reg.addr[fl2c_pkg::LW_BIT]) begin
            qword = {enc_lw(first_reg, badp), enc_lw(i_bus_rdata, badp)};
        end else begin
            qword = {enc_lw(i_bus_rdata, badp), enc_lw(first_reg, badp)};
        end
    end

    // ************************************************************
    // Arrays
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (fill_do) begin
            tag_mem[vs][req_reg.addr[fl2c_pkg::IDX_LO +: fl2c_pkg::ROW_W]]
                <= enc_tag(req_reg.addr[fl2c_pkg::TAG_LO +:
                                        fl2c_pkg::TAG_W], badp);
            dat_mem[vs][req_reg.addr[fl2c_pkg::IDX_LO +: fl2c_pkg::ROW_W]]
                <= qword;
        end else if (wr_do) begin
            dat_mem[ws][row] <= wdat;
            if (!chit_any) begin
                tag_mem[ws][row] <= enc_tag(
                    i_cpu.addr[fl2c_pkg::TAG_LO +: fl2c_pkg::TAG_W], badp);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            valid_reg <= '0;
        end else if (flush) begin
            valid_reg <= '0;
        end else begin
            if (dma_inv) begin
                valid_reg[{dset, drow}] <= 1'b0;
            end
            if (fill_do) begin
                valid_reg[{vs, req_reg.addr[fl2c_pkg::IDX_LO +:
                                            fl2c_pkg::ROW_W]}] <= 1'b1;
            end
            if (wr_do && test) begin
                valid_reg[{ws, row}] <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            victim_reg <= 1'b0;
        end else if (fill_do) begin
            victim_reg <= ~victim_reg;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg_reg <= fl2c_pkg::CFG_RST;
        end else if (dem_err) begin
            cfg_reg <= fl2c_pkg::CFG_RST;
        end else if (i_ipr_wr && i_ipr_addr == fl2c_pkg::IPR_CFG) begin
            cfg_reg <= i_ipr_wdata[7:0] & fl2c_pkg::CFG_RW;
        end
    end

    // New errors win over a clear in the same cycle
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            log_reg <= fl2c_pkg::LOG_RST;
        end else begin
            log_reg[6:0] <= (log_clr ? 7'h00 : log_reg[6:0]) |
                            log_set;
            if (take && cach) begin
                log_reg[fl2c_pkg::LOG_HIT] <= chit_any;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_ipr_rdata <= 32'h0000_0000;
        end else if (i_ipr_addr == fl2c_pkg::IPR_CFG) begin
            o_ipr_rdata <= {24'h00_0000,
                            cfg_reg | fl2c_pkg::CFG_ONES};
        end else if (i_ipr_addr == fl2c_pkg::IPR_LOG) begin
            o_ipr_rdata <= {24'h00_0000, log_reg};
        end else begin
            o_ipr_rdata <= 32'h0000_0000;
        end
    end

    // ************************************************************
    // Reference sequencer
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_reg <= ST_IDLE;
            req_reg <= '0;
            bus_reg <= '0;
            cach_reg <= 1'b0;
            kill_reg <= 1'b0;
            first_reg <= 32'h0000_0000;
            o_cpu_ack <= 1'b0;
            o_cpu_rdata <= 32'h0000_0000;
            o_mcheck <= 1'b0;
            o_prefetch_halt <= 1'b0;
        end else begin
            o_cpu_ack <= 1'b0;
            o_mcheck <= 1'b0;
            o_prefetch_halt <= 1'b0;
            kill_reg <= kill_reg | kill_now;
            case (st_reg)
                ST_IDLE: begin
                    if (take) begin
                        req_reg <= i_cpu;
                        cach_reg <= cach && !perr;
                        kill_reg <= 1'b0;
                        if (rd_hit && !perr) begin
                            o_cpu_ack <= 1'b1;
                            o_cpu_rdata <= strip(hd);
                        end else if (dem_err) begin
                            o_mcheck <= 1'b1;
                        end else if (perr && i_cpu.istream) begin
                            o_prefetch_halt <= 1'b1;
                        end else begin
                            // A request-data error refetches from the bus
                            st_reg <= ST_FIRST;
                            bus_reg.addr <= {i_cpu.addr[29:2], 2'b00};
                            bus_reg.be <= i_cpu.be;
                            bus_reg.wdata <= i_cpu.wdata;
                            if (i_cpu.write) begin
                                bus_reg.kind <= fl2c_pkg::FL2C_WRITE;
                            end else if (i_cpu.istream || !i_cpu.demand) begin
                                bus_reg.kind <= fl2c_pkg::FL2C_REQUEST;
                            end else begin
                                bus_reg.kind <= fl2c_pkg::FL2C_DEMAND;
                            end
                        end
                    end
                end
                ST_FIRST: begin
                    if (i_bus_ack) begin
                        st_reg <= ST_IDLE;
                        if (bus_mc) begin
                            o_mcheck <= 1'b1;
                        end else begin
                            o_cpu_ack <= 1'b1;
                            o_cpu_rdata <= i_bus_rdata;
                            if (cach_reg && !busp) begin
                                st_reg <= ST_FILL;
                                first_reg <= i_bus_rdata;
                                bus_reg.kind <= fl2c_pkg::FL2C_FILL;
                                bus_reg.addr[fl2c_pkg::LW_BIT] <=
                                    ~bus_reg.addr[fl2c_pkg::LW_BIT];
                            end
                        end
                    end
                end
                ST_FILL: begin
                    if (i_bus_ack) begin
                        st_reg <= ST_IDLE;
                    end
                end
                default: begin
                    st_reg <= ST_IDLE;
                end
            endcase
        end
    end

    assign o_cpu_ready = st_reg == ST_IDLE;
    assign o_bus_valid = st_reg != ST_IDLE;
    assign o_bus = bus_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    chk_hit_no_bus: assert property (
        rd_hit && !perr |=> o_cpu_ack && !o_bus_valid)
        else $error("cache hit started a bus transfer");
    chk_cfg_fixed: assert property (
        i_ipr_addr == fl2c_pkg::IPR_CFG |=>
        o_ipr_rdata[31:8] == 24'h00_0000 && o_ipr_rdata[3:2] == 2'b11)
        else $error("config fixed bits read wrong");
    chk_log_clear: assert property (
        log_clr && log_set == 7'h00 |=> log_reg[6:0] == 7'h00)
        else $error("log write did not clear");
    chk_fill_second: assert property (
        st_reg == ST_FIRST && i_bus_ack && cach_reg && !busp |=>
        st_reg == ST_FILL && o_bus.kind == fl2c_pkg::FL2C_FILL &&
        o_bus.addr[2] != $past(o_bus.addr[2]))
        else $error("fill longword not issued");
    chk_single_lw: assert property (
        st_reg == ST_FIRST && i_bus_ack && !cach_reg |=> st_reg == ST_IDLE)
        else $error("non-cacheable transfer not single");
    chk_cfg_flush: assert property (
        i_ipr_wr && i_ipr_addr == fl2c_pkg::IPR_CFG &&
        !i_ipr_wdata[fl2c_pkg::CFG_TEST] |=> valid_reg == 128'h0)
        else $error("config write did not flush");
    chk_demand_abort: assert property (
        dem_err |=> o_mcheck && cfg_reg == fl2c_pkg::CFG_RST &&
        log_reg[fl2c_pkg::LOG_BUSMC] && log_reg[fl2c_pkg::LOG_L1MC])
        else $error("demand parity error not aborted");
    chk_off_miss: assert property (
        take && !i_cpu.write && !cache_on |=> st_reg == ST_FIRST)
        else $error("disabled cache did not miss");
    chk_rei_flush: assert property (
        i_rei && is_only |=> valid_reg == 128'h0)
        else $error("return did not flush");
    chk_hit_flag: assert property (
        take && cach |=> log_reg[fl2c_pkg::LOG_HIT] == $past(chit_any))
        else $error("hit indicator wrong");
endmodule

`default_nettype wire

// ---- fl2c_pkg.sv ----
// Constants and carriers of the two-way first-level cache.
// Assumes one processor clock domain and a six-bit register number.
`default_nettype none

package fl2c_pkg;
    // ************************************************************
    // Address layout
    // ************************************************************
    localparam int ADDR_W = 30;
    localparam int ROW_W = 6;
    localparam int TAG_W = 20;
    localparam int IDX_LO = 3;
    localparam int TAG_LO = 9;
    localparam int IO_BIT = 29;
    localparam int LW_BIT = 2;

    // ************************************************************
    // Register numbers and fields
    // ************************************************************
    localparam logic [5:0] IPR_CFG = 6'h25;
    localparam logic [5:0] IPR_LOG = 6'h27;
    localparam int CFG_EN1 = 7;
    localparam int CFG_EN0 = 6;
    localparam int CFG_IS = 5;
    localparam int CFG_DS = 4;
    localparam int CFG_BADP = 1;
    localparam int CFG_TEST = 0;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] CFG_ONES = 8'h0c;
    localparam logic [7:0] CFG_RW = 8'hf3;
    localparam int LOG_HIT = 7;
    localparam int LOG_BUS = 6;
    localparam int LOG_BUSMC = 5;
    localparam int LOG_L1MC = 4;
    localparam int LOG_W1 = 3;
    localparam int LOG_W0 = 2;
    localparam int LOG_DAT = 1;
    localparam int LOG_TAG = 0;
    localparam logic [7:0] LOG_RST = 8'h00;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef enum logic [1:0] {
        FL2C_DEMAND,
        FL2C_REQUEST,
        FL2C_FILL,
        FL2C_WRITE
    } fl2c_kind_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic write;
        logic istream;
        logic demand;
        logic lock;
        logic [3:0] be;
        logic [31:0] wdata;
    } fl2c_cpu_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        fl2c_kind_t kind;
        logic [3:0] be;
        logic [31:0] wdata;
    } fl2c_bus_req_t;
endpackage

`default_nettype wire

// ---- fl2c_bus_model.sv ----
// Bus partner: answers each request after 0 to 3 wait cycles.
// Assumes a request holds until its ack pulse is sampled.
`default_nettype none
module fl2c_bus_model (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_bus_valid,
    input wire fl2c_pkg::fl2c_bus_req_t i_bus,
    input wire logic i_perr_req,
    output logic o_bus_ack,
    output logic [31:0] o_bus_rdata,
    output logic o_bus_perr
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_cnt;
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_bus_ack <= 1'b0;
            o_bus_perr <= 1'b0;
            o_bus_rdata <= 32'h0;
            wait_cnt = 0;
        end else if (o_bus_ack) begin
            // Data flips once released, so stale data never matches
            o_bus_ack <= 1'b0;
            o_bus_perr <= 1'b0;
            o_bus_rdata <= ~o_bus_rdata;
        end else if (i_bus_valid && wait_cnt > 0) begin
            wait_cnt--;
        end else if (i_bus_valid) begin
            o_bus_ack <= 1'b1;
            o_bus_perr <= i_perr_req;
            o_bus_rdata <= {i_bus.addr[29:2], 2'h0} ^ 32'h3c5a96e1;
            wait_cnt = $urandom_range(3, 0);
        end
    end
endmodule
`default_nettype wire

// ---- fl2c_top_tb.sv ----
// Self-checking bench of the first-level cache with random addresses.
// Assumes the bus model shares i_clk with the design.
`default_nettype none
module fl2c_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] DMD = 4'h2, IST = 4'h4;
    localparam logic [5:0] CFG = fl2c_pkg::IPR_CFG, LOG = fl2c_pkg::IPR_LOG;
    logic i_clk = 1'b0, i_resetn = 1'b0, i_cpu_valid = 1'b0, i_rei = 1'b0;
    logic i_dma_wr = 1'b0, i_ipr_wr = 1'b0, perr = 1'b0;
    fl2c_pkg::fl2c_cpu_req_t i_cpu = '0;
    logic [29:0] i_dma_addr = '0, a, b;
    logic [5:0] i_ipr_addr = '0;
    logic [31:0] i_ipr_wdata = '0, rd, w;
    logic o_cpu_ready, o_cpu_ack, o_mcheck, o_prefetch_halt, o_bus_valid;
    logic i_bus_ack, i_bus_perr;
    logic [31:0] o_cpu_rdata, o_ipr_rdata, i_bus_rdata;
    fl2c_pkg::fl2c_bus_req_t o_bus;
    logic [31:0] busq[$];
    logic [2:0] resp;
    int error_cnt = 0, compares = 0;
    always #20 i_clk = ~i_clk;
    fl2c_top u_dut (.*);
    fl2c_bus_model u_bus (.i_clk, .i_resetn, .i_bus_valid(o_bus_valid),
        .i_bus(o_bus), .i_perr_req(perr), .o_bus_ack(i_bus_ack),
        .o_bus_rdata(i_bus_rdata), .o_bus_perr(i_bus_perr));
    always @(posedge i_clk) if (o_bus_valid && i_bus_ack)
        busq.push_back({o_bus.kind, o_bus.addr});
    function automatic logic [31:0] mv(logic [29:0] x);
        return {x[29:2], 2'h0} ^ 32'h3c5a96e1;
    endfunction
    function automatic logic [31:0] bq(logic [1:0] k, logic [29:0] x);
        return {k, x[29:2], 2'h0};
    endfunction
    task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic ipr(logic wr, logic [5:0] ad, logic [31:0] d);
        @(posedge i_clk);
        i_ipr_wr <= wr;
        i_ipr_addr <= ad;
        i_ipr_wdata <= d;
        @(posedge i_clk);
        i_ipr_wr <= 1'b0;
        @(posedge i_clk);
        #1 rd = o_ipr_rdata;
    endtask
    task automatic cpu(logic [29:0] x, logic [3:0] c, logic [3:0] be);
        int n;
        n = 0;
        busq.delete();
        @(posedge i_clk);
        i_cpu_valid <= 1'b1;
        i_cpu <= {x, c, be, w};
        @(posedge i_clk);
        i_cpu_valid <= 1'b0;
        #1;
        while (!(o_cpu_ack | o_mcheck | o_prefetch_halt) && n < 99) begin
            @(posedge i_clk);
            #1 n++;
        end
        resp = {o_mcheck, o_prefetch_halt, o_cpu_ack};
        rd = o_cpu_rdata;
        while (o_cpu_ready !== 1'b1 && n < 99) begin
            @(posedge i_clk);
            #1 n++;
        end
        if (n >= 99) chk("ready", 0, 1);
    endtask
    task automatic pulse(logic d);
        @(posedge i_clk);
        {i_rei, i_dma_wr} <= {!d, d};
        i_dma_addr <= a;
        @(posedge i_clk);
        {i_rei, i_dma_wr} <= 2'h0;
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #400000 error_cnt++;
        end_of_test();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'hc649));
        w = 0;
        repeat (4) @(posedge i_clk);
        i_resetn <= 1'b1;
        ipr(0, CFG, 0);
        chk("cfg", 32'h0c, rd);
        ipr(0, LOG, 0);
        chk("log", 0, rd);
        ipr(1, CFG, 32'hffff_fff0);
        chk("cfg", 32'hfc, rd);
        for (int i = 0; i < 8; i++) begin
            a = {1'b0, 29'($urandom())};
            cpu(a, i[0] ? IST : DMD, 4'hf);
            chk("miss", {mv(a), 32'h2},
                {rd, 32'(busq.size())});
            chk("seq", {bq(i[0], a), bq(2, a ^ 4)}, {busq[0], busq[1]});
            ipr(0, LOG, 0);
            chk("log", 0, rd);
            cpu(a ^ 30'h4, i[0] ? IST : DMD, 4'hf);
            chk("hit", {mv(a ^ 4), 32'h0},
                {rd, 32'(busq.size())});
            ipr(0, LOG, 0);
            chk("log", 32'h80, rd);
        end
        w = $urandom();
        cpu(a, 4'h8, 4'h2);
        chk("wr", bq(3, a), busq[0]);
        cpu(a, IST, 4'hf);
        chk("merge", mv(a) & 32'hffff00ff | w & 32'hff00, rd);
        cpu(a, 4'h3, 4'hf);
        chk("lock", 1, busq.size());
        cpu(a | 30'h2000_0000, DMD, 4'hf);
        chk("io", 1, busq.size());
        ipr(1, CFG, 32'hf0);
        cpu(a, IST, 4'hf);
        chk("flush", 2, busq.size());
        pulse(1);
        cpu(a, IST, 4'hf);
        chk("dma", 2, busq.size());
        ipr(1, CFG, 32'he0);
        cpu(a, IST, 4'hf);
        pulse(0);
        cpu(a, IST, 4'hf);
        chk("rei", 2, busq.size());
        ipr(1, CFG, 32'h30);
        cpu(a, DMD, 4'hf);
        chk("off", 1, busq.size());
        ipr(1, CFG, 32'hc0);
        cpu(a, IST, 4'hf);
        chk("off", 1, busq.size());
        ipr(1, CFG, 32'hf0);
        b = a ^ 30'h1000;
        @(posedge i_clk) perr <= 1'b1;
        cpu(b, DMD, 4'hf);
        ipr(0, LOG, 0);
        chk("perr", {32'h4, 32'h60}, {29'h0, resp, rd});
        ipr(1, LOG, $urandom());
        chk("clr", 0, rd);
        cpu(b, 4'h0, 4'hf);
        ipr(0, LOG, 0);
        chk("perr", {32'h1, 32'h40}, {29'h0, resp, rd});
        ipr(1, LOG, 0);
        chk("clr", 0, rd);
        @(posedge i_clk) perr <= 1'b0;
        ipr(1, CFG, 32'hf2);
        cpu(b, DMD, 4'hf);
        cpu(b, DMD, 4'hf);
        ipr(0, CFG, 0);
        chk("abort", {32'h4, 32'h0c}, {29'h0, resp, rd});
        ipr(0, LOG, 0);
        chk("log", 32'hb3, rd & 32'hf3);
        ipr(1, LOG, 0);
        ipr(1, CFG, 32'hf2);
        cpu(b, IST, 4'hf);
        cpu(b, IST, 4'hf);
        ipr(0, CFG, 0);
        chk("halt", {32'h2, 32'hfe}, {29'h0, resp, rd});
        ipr(0, LOG, 0);
        chk("log", 32'h83, rd & 32'hf3);
        // Test mode with exactly one set on
        ipr(1, CFG, 32'h71);
        w = $urandom();
        cpu(b, 4'h8, 4'hf);
        ipr(1, CFG, 32'h71);
        cpu(b, DMD, 4'hf);
        chk("test", {w, 32'h0}, {rd, 32'(busq.size())});
        end_of_test();
    end
endmodule
`default_nettype wire
